// File: rtl/cdsa_core.sv
// data registers, status word, interrupt gate and effective-address unit
`timescale 1ns/100ps
module cdsa_core (
  input wire logic clk_sys,
  input wire logic resetn,
  // register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // alu operation from decoder
  input wire logic alu_go,
  input wire cdsa_pkg::cdsa_aluop_t alu_op,
  input wire logic alu_word,
  input wire logic [1:0] alu_dst,
  input wire logic [1:0] alu_src,
  input wire logic alu_src_imm,
  input wire logic [15:0] alu_imm,
  input wire logic flag_we,
  output logic [15:0] alu_result,
  // memory load into and store from data registers
  input wire logic load_go,
  input wire logic load_word,
  input wire logic [1:0] load_dst,
  input wire logic [15:0] load_data,
  output logic [15:0] store_data,
  input wire logic [1:0] store_sel,
  input wire logic store_word,
  // interrupt gate
  input wire logic irq_req,
  input wire logic [1:0] irq_level,
  input wire logic nmi_req,
  output logic irq_accept,
  output logic nmi_accept,
  input wire logic irq_return,
  output logic stack_full,
  // effective address
  input wire logic ea_go,
  input wire cdsa_pkg::cdsa_amode_t ea_mode,
  input wire cdsa_pkg::cdsa_iclass_t ea_class,
  input wire logic [15:0] areg,
  input wire logic [15:0] sp,
  input wire logic [17:0] pc,
  input wire logic [15:0] ea_disp,
  input wire logic [4:0] disp_bits,
  input wire logic half_sel,
  output logic [17:0] ea_addr,
  output logic ea_valid,
  output logic ea_illegal,
  output logic [7:0] psw
);
  // --------------------------------
  // reset release
  // --------------------------------
  logic rst_m_q;
  logic rst_n_q;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rst_m_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_n_q <= rst_m_q;
    end
  end

  // --------------------------------
  // data registers
  // --------------------------------
  logic [7:0] dreg_q [cdsa_pkg::NUM_DREG];
  logic [15:0] alu_a;
  logic [15:0] alu_b;
  logic [15:0] alu_res;
  logic alu_zf;
  logic alu_cf;
  logic alu_nf;
  logic alu_vf;

  // word pair read: odd byte high, even byte low
  function automatic logic [15:0] pair_rd(input logic [7:0] hi, input logic [7:0] lo);
    pair_rd = {hi, lo};
  endfunction

  function automatic logic [15:0] operand(input logic [1:0] sel, input logic word,
                                          input logic [7:0] d0, input logic [7:0] d1,
                                          input logic [7:0] d2, input logic [7:0] d3);
    logic [7:0] b;
    b = (sel == 2'h0) ? d0 : (sel == 2'h1) ? d1 : (sel == 2'h2) ? d2 : d3;
    if (word) begin
      operand = sel[1] ? pair_rd(d3, d2) : pair_rd(d1, d0);
    end else begin
      operand = {8'h00, b};
    end
  endfunction

  assign alu_a = operand(alu_dst, alu_word, dreg_q[0], dreg_q[1], dreg_q[2], dreg_q[3]);
  assign alu_b = alu_src_imm ? alu_imm
               : operand(alu_src, alu_word, dreg_q[0], dreg_q[1], dreg_q[2], dreg_q[3]);

  cdsa_alu u_alu (
    .a(alu_a),
    .b(alu_b),
    .word(alu_word),
    .op(alu_op),
    .res(alu_res),
    .zf(alu_zf),
    .cf(alu_cf),
    .nf(alu_nf),
    .vf(alu_vf)
  );

  // no reset here: contents are undefined until software writes them
  genvar gi;
  generate
    for (gi = 0; gi < cdsa_pkg::NUM_DREG; gi++) begin : g_dreg
      always_ff @(posedge clk_sys) begin
        if (reg_wr && reg_addr == 3'(gi)) begin
          dreg_q[gi] <= reg_wdata;
        end else if (alu_go && (alu_word ? (alu_dst[1] == 1'(gi / 2))
                                         : (alu_dst == 2'(gi)))) begin
          dreg_q[gi] <= (alu_word && (gi % 2 == 1)) ? alu_res[15:8] : alu_res[7:0];
        end else if (load_go && (load_word ? (load_dst[1] == 1'(gi / 2))
                                           : (load_dst == 2'(gi)))) begin
          dreg_q[gi] <= (load_word && (gi % 2 == 1)) ? load_data[15:8] : load_data[7:0];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    alu_result <= alu_res;
    store_data <= operand(store_sel, store_word, dreg_q[0], dreg_q[1], dreg_q[2], dreg_q[3]);
  end

  // --------------------------------
  // status word and interrupt gate
  // --------------------------------
  logic [7:0] psw_q;
  logic [cdsa_pkg::STACK_AW:0] sp_cnt_q;
  logic [7:0] pop_data;
  logic pop_pend_q;
  logic irq_ok;
  logic [1:0] mask_lvl;

  assign mask_lvl = psw_q[cdsa_pkg::IM_HI_BIT:cdsa_pkg::IM_LO_BIT];
  assign irq_ok = irq_req && psw_q[cdsa_pkg::MIE_BIT]
                  && (irq_level < mask_lvl) && !nmi_req;
  assign irq_accept = irq_ok && !stack_full;
  assign nmi_accept = nmi_req && !stack_full;
  assign stack_full = sp_cnt_q[cdsa_pkg::STACK_AW];
  assign psw = psw_q;

  cdsa_psw_stack u_stack (
    .clk_sys(clk_sys),
    .we(irq_accept || nmi_accept),
    .waddr(sp_cnt_q[cdsa_pkg::STACK_AW-1:0]),
    .wdata(psw_q),
    .raddr(sp_cnt_q[cdsa_pkg::STACK_AW-1:0] - 3'h1),
    .rdata(pop_data)
  );

  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sp_cnt_q <= '0;
      pop_pend_q <= 1'b0;
    end else begin
      pop_pend_q <= irq_return && (sp_cnt_q != '0) && !(irq_accept || nmi_accept);
      if (irq_accept || nmi_accept) begin
        sp_cnt_q <= sp_cnt_q + 4'h1;
      end else if (irq_return && sp_cnt_q != '0) begin
        sp_cnt_q <= sp_cnt_q - 4'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      psw_q <= cdsa_pkg::PSW_RST;
    end else if (pop_pend_q) begin
      psw_q <= pop_data;
    end else if (reg_wr && reg_addr == cdsa_pkg::OFF_PSW) begin
      psw_q <= reg_wdata & cdsa_pkg::PSW_WMASK;
    end else if (nmi_accept) begin
      psw_q[cdsa_pkg::IM_HI_BIT:cdsa_pkg::IM_LO_BIT] <= 2'h0;
    end else if (irq_accept) begin
      psw_q[cdsa_pkg::IM_HI_BIT:cdsa_pkg::IM_LO_BIT] <= irq_level;
    end else if (alu_go && flag_we) begin
      psw_q[cdsa_pkg::ZF_BIT] <= alu_zf;
      psw_q[cdsa_pkg::CF_BIT] <= alu_cf;
      psw_q[cdsa_pkg::NF_BIT] <= alu_nf;
      psw_q[cdsa_pkg::VF_BIT] <= alu_vf;
    end
  end

  // --------------------------------
  // effective address
  // --------------------------------
  logic [15:0] last_addr_q;
  logic [15:0] dmask;
  logic [17:0] ea_d;
  logic ill_d;

  always_comb begin
    dmask = 16'hFFFF >> (5'h10 - ((disp_bits > 5'h10) ? 5'h10 : disp_bits));
    ea_d = 18'h00000;
    ill_d = 1'b0;
    case (ea_mode)
      cdsa_pkg::CDSA_AM_REG_DIRECT,
      cdsa_pkg::CDSA_AM_IMM: ea_d = 18'h00000;
      cdsa_pkg::CDSA_AM_REG_IND: ea_d = {2'h0, areg};
      cdsa_pkg::CDSA_AM_REG_REL8: ea_d = {2'h0, areg + {{8{ea_disp[7]}}, ea_disp[7:0]}};
      cdsa_pkg::CDSA_AM_REG_REL16: ea_d = {2'h0, areg + ea_disp};
      // displacement zero-extended to its width for stack offsets
      cdsa_pkg::CDSA_AM_SP_REL: ea_d = {2'h0, sp + (ea_disp & dmask)};
      cdsa_pkg::CDSA_AM_ABS: ea_d = {2'h0, ea_disp & dmask};
      cdsa_pkg::CDSA_AM_RAM_SHORT: ea_d = {2'h0, cdsa_pkg::RAM_BASE + {8'h00, ea_disp[7:0]}};
      cdsa_pkg::CDSA_AM_IO_SHORT:
        ea_d = {2'h0, cdsa_pkg::PERIPH_BASE + {8'h00, ea_disp[7:0]}};
      cdsa_pkg::CDSA_AM_LAST_ADDR: ea_d = {2'h0, last_addr_q};
      cdsa_pkg::CDSA_AM_PC_REL: begin
        // half-byte address: low bit of pc and result is the half-byte select
        ea_d = pc + {{2{ea_disp[15]}}, ea_disp} + {17'h00000, half_sel};
      end
      cdsa_pkg::CDSA_AM_ABS18: ea_d = {1'b0, ea_disp, half_sel};
      default: ill_d = 1'b1;
    endcase
    // addressing-mode legality per instruction class
    if (ea_class == cdsa_pkg::CDSA_IC_ALU && ea_mode != cdsa_pkg::CDSA_AM_REG_DIRECT
        && ea_mode != cdsa_pkg::CDSA_AM_IMM) begin
      ill_d = 1'b1;
    end
    if (ea_mode == cdsa_pkg::CDSA_AM_LAST_ADDR && ea_class != cdsa_pkg::CDSA_IC_BYTE_MOVE
        && ea_class != cdsa_pkg::CDSA_IC_WORD_MOVE) begin
      ill_d = 1'b1;
    end
    if ((ea_mode == cdsa_pkg::CDSA_AM_PC_REL || ea_mode == cdsa_pkg::CDSA_AM_ABS18)
        && ea_class != cdsa_pkg::CDSA_IC_BRANCH) begin
      ill_d = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ea_addr <= 18'h00000;
      ea_valid <= 1'b0;
      ea_illegal <= 1'b0;
      last_addr_q <= 16'h0000;
    end else begin
      ea_valid <= ea_go && !ill_d;
      ea_illegal <= ea_go && ill_d;
      if (ea_go) begin
        ea_addr <= ea_d;
      end
      // word transfers keep any byte alignment; no low-bit masking
      if (ea_go && !ill_d && ea_class != cdsa_pkg::CDSA_IC_BRANCH
          && ea_mode != cdsa_pkg::CDSA_AM_REG_DIRECT && ea_mode != cdsa_pkg::CDSA_AM_IMM) begin
        last_addr_q <= ea_d[15:0];
      end
    end
  end

  // --------------------------------
  // register read port
  // --------------------------------
  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr <= cdsa_pkg::OFF_DREG3) begin
        reg_rdata <= dreg_q[reg_addr[1:0]];
      end else if (reg_addr == cdsa_pkg::OFF_PSW) begin
        reg_rdata <= psw_q;
      end else if (reg_addr == cdsa_pkg::OFF_STAT) begin
        reg_rdata <= {4'h0, sp_cnt_q};
      end else begin
        reg_rdata <= 8'h00;
      end
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // --------------------------------
  // checks
  // --------------------------------
  mie_blocks_a: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    !psw_q[cdsa_pkg::MIE_BIT] |-> !irq_accept) else $error("irq taken with enable low");
  level_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    irq_accept |-> irq_level < psw_q[5:4]) else $error("irq level not below mask");
  mask_load_a: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    irq_accept && !(reg_wr && reg_addr == cdsa_pkg::OFF_PSW) && !pop_pend_q
    |=> psw_q[5:4] == $past(irq_level)) else $error("mask not loaded");
  mie_kept_a: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    (irq_accept || nmi_accept) && !(reg_wr && reg_addr == cdsa_pkg::OFF_PSW) && !pop_pend_q
    |=> $stable(psw_q[cdsa_pkg::MIE_BIT])) else $error("enable changed by irq");
  zero_flag_a: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    alu_go && flag_we && !pop_pend_q && !reg_wr && !irq_accept && !nmi_accept
    |=> psw_q[0] == (alu_result == 16'h0000)) else $error("zero flag wrong");
  neg_flag_a: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    alu_go && flag_we && !pop_pend_q && !reg_wr && !irq_accept && !nmi_accept
    |=> psw_q[2] == ($past(alu_word) ? alu_result[15] : alu_result[7]))
    else $error("negative flag wrong");
  psw_restore_a: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    (irq_accept && !pop_pend_q && !reg_wr) ##1 (irq_return && !irq_accept && !nmi_accept)
    |=> ##1 psw_q == $past(psw_q, 3)) else $error("status not restored");
  handy_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    ea_go && ea_mode == cdsa_pkg::CDSA_AM_LAST_ADDR && ea_class == cdsa_pkg::CDSA_IC_ALU
    |=> ea_illegal && !ea_valid) else $error("reuse mode allowed for alu");
  io_short_a: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    ea_go && ea_mode == cdsa_pkg::CDSA_AM_IO_SHORT && ea_class != cdsa_pkg::CDSA_IC_ALU
    |=> ea_addr == {2'h0, cdsa_pkg::PERIPH_BASE + {8'h00, $past(ea_disp[7:0])}})
    else $error("io short address wrong");
endmodule // cdsa_core

// File: rtl/cdsa_pkg.sv
// package of constants and types for the cpu data, status and addressing block
// What this block does
// - four 8-bit data byte registers for operations and memory transfers
// - byte registers pair into two 16-bit words, odd byte high
// - data registers are not reset; contents undefined after reset
// - one 8-bit status word holds flags, two-bit mask level, enable
// - status word pushed on interrupt entry, restored on return
// - zero flag set when every result bit is zero
// - carry flag set on carry out of or borrow into msb
// - negative flag copies the result msb
// - overflow flag set on two's-complement signed overflow
// - mask field encodes levels 0 to 3, 00 most restrictive
// - maskable request accepted only when its level is below mask level
// - acceptance loads mask field with accepted level
// - enable bit zero blocks all maskable requests
// - acceptance never changes the enable bit
// - last-address reuse mode only for byte and word moves
// - arithmetic and logic take only register direct or immediate operands
// - 16-bit memory transfers allowed at odd or even addresses
// - register relative adds 8- or 16-bit displacement; indirect uses register
// - pc relative adds 4/7/11/12/16-bit displacement plus half-byte bit, 18-bit
// - stack relative adds 4-, 8- or 16-bit displacement to stack pointer
// - absolute 8/12/16-bit operand; 18-bit form for branches only
// - ram short offsets from zero; i/o short adds peripheral register base
package cdsa_pkg;
  localparam int DATA_W = 8;
  localparam int WORD_W = 16;
  localparam int PC_W = 18;
  localparam int NUM_DREG = 4;
  // status word field positions
  localparam int ZF_BIT = 0;
  localparam int CF_BIT = 1;
  localparam int NF_BIT = 2;
  localparam int VF_BIT = 3;
  localparam int IM_LO_BIT = 4;
  localparam int IM_HI_BIT = 5;
  localparam int MIE_BIT = 6;
  localparam logic [7:0] PSW_RST = 8'h00;
  localparam logic [7:0] PSW_WMASK = 8'h7F;
  // register port offsets
  localparam logic [2:0] OFF_DREG0 = 3'h0;
  localparam logic [2:0] OFF_DREG3 = 3'h3;
  localparam logic [2:0] OFF_PSW = 3'h4;
  localparam logic [2:0] OFF_STAT = 3'h5;
  localparam logic [15:0] PERIPH_BASE = 16'h3F00;
  localparam logic [15:0] RAM_BASE = 16'h0000;
  localparam int STACK_DEPTH = 8;
  localparam int STACK_AW = 3;
  typedef enum logic [3:0] {
    CDSA_AM_REG_DIRECT, CDSA_AM_IMM, CDSA_AM_REG_IND, CDSA_AM_REG_REL8,
    CDSA_AM_REG_REL16, CDSA_AM_SP_REL, CDSA_AM_ABS, CDSA_AM_RAM_SHORT,
    CDSA_AM_IO_SHORT, CDSA_AM_LAST_ADDR, CDSA_AM_PC_REL, CDSA_AM_ABS18
  } cdsa_amode_t;
  typedef enum logic [1:0] {
    CDSA_IC_ALU, CDSA_IC_BYTE_MOVE, CDSA_IC_WORD_MOVE, CDSA_IC_BRANCH
  } cdsa_iclass_t;
  typedef enum logic [2:0] {
    CDSA_OP_ADD, CDSA_OP_SUB, CDSA_OP_AND, CDSA_OP_OR, CDSA_OP_XOR, CDSA_OP_SHL,
    CDSA_OP_SHR, CDSA_OP_PASS
  } cdsa_aluop_t;
endpackage

// File: rtl/cdsa_psw_stack.sv
// small memory holding pushed status words, registered read data
`timescale 1ns/100ps
module cdsa_psw_stack (
  input wire logic clk_sys,
  input wire logic we,
  input wire logic [cdsa_pkg::STACK_AW-1:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [cdsa_pkg::STACK_AW-1:0] raddr,
  output logic [7:0] rdata
);
  logic [7:0] mem [cdsa_pkg::STACK_DEPTH];

  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    rdata <= mem[raddr];
  end
endmodule // cdsa_psw_stack

// File: rtl/cdsa_alu.sv
// byte or word alu with result flags
`timescale 1ns/100ps
module cdsa_alu (
  input wire logic [15:0] a,
  input wire logic [15:0] b,
  input wire logic word,
  input wire cdsa_pkg::cdsa_aluop_t op,
  output logic [15:0] res,
  output logic zf,
  output logic cf,
  output logic nf,
  output logic vf
);
  logic [16:0] ext;
  logic msb_a;
  logic msb_b;
  logic msb_r;
  logic arith;

  always_comb begin
    ext = 17'h00000;
    arith = 1'b0;
    case (op)
      cdsa_pkg::CDSA_OP_ADD: begin
        ext = {1'b0, a} + {1'b0, b};
        arith = 1'b1;
      end
      cdsa_pkg::CDSA_OP_SUB: begin
        ext = {1'b0, a} - {1'b0, b};
        arith = 1'b1;
      end
      cdsa_pkg::CDSA_OP_AND: ext = {1'b0, a & b};
      cdsa_pkg::CDSA_OP_OR: ext = {1'b0, a | b};
      cdsa_pkg::CDSA_OP_XOR: ext = {1'b0, a ^ b};
      cdsa_pkg::CDSA_OP_SHL: ext = {a, 1'b0};
      cdsa_pkg::CDSA_OP_SHR: ext = {a[0], 1'b0, a[15:1]};
      default: ext = {1'b0, b};
    endcase
    // byte mode: add, sub and shift-left carry is the bit above bit 7
    if (!word) begin
      if (op == cdsa_pkg::CDSA_OP_ADD) begin
        ext[16] = ext[8] ^ a[8] ^ b[8];
      end else if (op == cdsa_pkg::CDSA_OP_SUB) begin
        ext[16] = ext[8] ^ a[8] ^ b[8];
      end else if (op == cdsa_pkg::CDSA_OP_SHL) begin
        ext[16] = a[7];
      end
      res = {8'h00, ext[7:0]};
    end else begin
      res = ext[15:0];
    end
    msb_a = word ? a[15] : a[7];
    msb_b = word ? b[15] : b[7];
    msb_r = word ? res[15] : res[7];
    zf = (res == 16'h0000);
    cf = ext[16];
    nf = msb_r;
    vf = 1'b0;
    if (arith) begin
      if (op == cdsa_pkg::CDSA_OP_ADD) begin
        vf = (msb_a == msb_b) && (msb_r != msb_a);
      end else begin
        vf = (msb_a != msb_b) && (msb_r != msb_a);
      end
    end
  end
endmodule // cdsa_alu

// File: sim/cdsa_irq_partner.sv
// interrupt controller model: posts one request and holds it until taken or dropped
`timescale 1ns/100ps
module cdsa_irq_partner (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic post,
  input wire logic post_nmi,
  input wire logic drop,
  input wire logic [1:0] post_level,
  input wire logic irq_accept,
  input wire logic nmi_accept,
  output logic irq_req,
  output logic [1:0] irq_level,
  output logic nmi_req
);
  // ----------------------------------------
  // request lines
  // ----------------------------------------
  logic req_q;
  logic nmi_q;
  logic [1:0] level_q;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      req_q <= 1'b0;
      level_q <= 2'h0;
    end else if (post) begin
      req_q <= 1'b1;
      level_q <= post_level;
    end else if (irq_accept || drop) begin
      req_q <= 1'b0;
    end
  end
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      nmi_q <= 1'b0;
    end else if (post_nmi) begin
      nmi_q <= 1'b1;
    end else if (nmi_accept || drop) begin
      nmi_q <= 1'b0;
    end
  end
  // a released level line shows junk, never the last level
  assign irq_req = req_q;
  assign irq_level = req_q ? level_q : ~level_q;
  assign nmi_req = nmi_q;
endmodule // cdsa_irq_partner

// File: sim/cdsa_core_bench.sv
// self-checking bench for the cpu data, status and addressing core
`timescale 1ns/100ps
module cdsa_core_bench;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic alu_go = 1'b0;
  cdsa_pkg::cdsa_aluop_t alu_op = cdsa_pkg::CDSA_OP_ADD;
  logic alu_word = 1'b0;
  logic [1:0] alu_dst = 2'h0;
  logic [15:0] alu_imm = 16'h0000;
  logic load_go = 1'b0;
  logic load_word = 1'b0;
  logic [1:0] load_dst = 2'h0;
  logic [15:0] load_data = 16'h0000;
  logic [1:0] store_sel = 2'h0;
  logic store_word = 1'b0;
  logic irq_return = 1'b0;
  logic post = 1'b0;
  logic post_nmi = 1'b0;
  logic drop = 1'b0;
  logic [1:0] post_level = 2'h0;
  logic ea_go = 1'b0;
  cdsa_pkg::cdsa_amode_t ea_mode = cdsa_pkg::CDSA_AM_REG_DIRECT;
  cdsa_pkg::cdsa_iclass_t ea_class = cdsa_pkg::CDSA_IC_ALU;
  logic [15:0] areg = 16'h0000;
  logic [15:0] ea_disp = 16'h0000;
  logic [4:0] disp_bits = 5'h00;
  logic half_sel = 1'b0;
  logic irq_req, nmi_req, irq_accept, nmi_accept, stack_full, ea_valid, ea_illegal;
  logic [1:0] irq_level;
  logic [7:0] reg_rdata, psw;
  logic [15:0] alu_result, store_data;
  logic [17:0] ea_addr;
  int mismatches = 0;
  int comparisons = 0;
  always #10 clk_sys = ~clk_sys;
  // sp, pc and the operand source are held fixed to keep the bench short
  cdsa_core cdsa_core_i (.clk_sys, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .alu_go, .alu_op, .alu_word, .alu_dst, .alu_src(2'h0), .alu_src_imm(1'b1),
    .alu_imm, .flag_we(1'b1), .alu_result, .load_go, .load_word, .load_dst, .load_data,
    .store_data, .store_sel, .store_word, .irq_req, .irq_level, .nmi_req, .irq_accept,
    .nmi_accept, .irq_return, .stack_full, .ea_go, .ea_mode, .ea_class, .areg,
    .sp(16'h0200), .pc(18'h00100), .ea_disp, .disp_bits, .half_sel, .ea_addr, .ea_valid,
    .ea_illegal, .psw);
  cdsa_irq_partner cdsa_irq_partner_i (.clk_sys, .resetn, .post, .post_nmi, .drop,
    .post_level, .irq_accept, .nmi_accept, .irq_req, .irq_level, .nmi_req);
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic check(input string name, input logic [17:0] seen, input logic [17:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rchk(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    check("register read", reg_rdata, e);
  endtask
  task automatic alu(input cdsa_pkg::cdsa_aluop_t op, input logic w, input logic [1:0] d,
                     input logic [15:0] imm, input logic [15:0] er, input logic [3:0] ef);
    @(posedge clk_sys);
    alu_go <= 1'b1;
    alu_op <= op;
    alu_word <= w;
    alu_dst <= d;
    alu_imm <= imm;
    @(posedge clk_sys);
    alu_go <= 1'b0;
    #1;
    check("alu result", w ? alu_result : {8'h00, alu_result[7:0]}, er);
    check("result flags", psw[3:0], ef);
  endtask
  task automatic irq(input logic [1:0] lv, input logic ok);
    @(posedge clk_sys);
    post <= 1'b1;
    post_level <= lv;
    @(posedge clk_sys);
    post <= 1'b0;
    #1;
    check("irq accept", irq_accept, ok);
    @(posedge clk_sys);
    drop <= 1'b1;
    @(posedge clk_sys);
    drop <= 1'b0;
    #1;
  endtask
  task automatic ret(input logic [7:0] e);
    @(posedge clk_sys);
    irq_return <= 1'b1;
    @(posedge clk_sys);
    irq_return <= 1'b0;
    @(posedge clk_sys);
    #1;
    check("psw restored", psw, e);
  endtask
  task automatic ea(input cdsa_pkg::cdsa_amode_t m, input cdsa_pkg::cdsa_iclass_t c,
                    input logic [15:0] a, input logic [15:0] dsp, input logic [4:0] nb,
                    input logic h, input logic [17:0] e, input logic bad);
    @(posedge clk_sys);
    ea_go <= 1'b1;
    ea_mode <= m;
    ea_class <= c;
    areg <= a;
    ea_disp <= dsp;
    disp_bits <= nb;
    half_sel <= h;
    @(posedge clk_sys);
    ea_go <= 1'b0;
    #1;
    check("ea illegal", ea_illegal, bad);
    check("ea valid", ea_valid, !bad);
    if (!bad)
      check("ea address", ea_addr, e);
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (3000) @(posedge clk_sys);
    mismatches++;
    close_out;
  end
  initial begin
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    check("psw after reset", psw, 8'h00);
    check("stack full", stack_full, 1'b0);
    rchk(cdsa_pkg::OFF_PSW, 8'h00);
    for (int i = 0; i < 4; i++)
      wr(3'(i), 8'(8'h11 * (i + 1)));
    for (int i = 0; i < 4; i++)
      rchk(3'(i), 8'(8'h11 * (i + 1)));
    wr(cdsa_pkg::OFF_PSW, 8'hFF);
    rchk(cdsa_pkg::OFF_PSW, cdsa_pkg::PSW_WMASK);
    wr(3'h6, 8'h5A);
    rchk(3'h6, 8'h00);
    wr(cdsa_pkg::OFF_PSW, 8'h00);
    // word load lands odd byte high
    @(posedge clk_sys);
    load_go <= 1'b1;
    load_word <= 1'b1;
    load_dst <= 2'h2;
    load_data <= 16'hA55A;
    @(posedge clk_sys);
    load_go <= 1'b0;
    rchk(3'h3, 8'hA5);
    rchk(3'h2, 8'h5A);
    @(posedge clk_sys);
    store_sel <= 2'h2;
    store_word <= 1'b1;
    @(posedge clk_sys);
    store_sel <= 2'h3;
    store_word <= 1'b0;
    #1;
    check("word store", store_data, 16'hA55A);
    @(posedge clk_sys);
    #1;
    check("byte store", store_data[7:0], 8'hA5);
    wr(3'h3, 8'h7F);
    alu(cdsa_pkg::CDSA_OP_ADD, 1'b0, 2'h3, 16'h0001, 16'h0080, 4'hC);
    alu(cdsa_pkg::CDSA_OP_ADD, 1'b0, 2'h3, 16'h0080, 16'h0000, 4'hB);
    alu(cdsa_pkg::CDSA_OP_SUB, 1'b0, 2'h3, 16'h0001, 16'h00FF, 4'h6);
    alu(cdsa_pkg::CDSA_OP_AND, 1'b0, 2'h3, 16'h000F, 16'h000F, 4'h0);
    alu(cdsa_pkg::CDSA_OP_XOR, 1'b0, 2'h3, 16'h000F, 16'h0000, 4'h1);
    wr(3'h0, 8'h00);
    wr(3'h1, 8'hFF);
    alu(cdsa_pkg::CDSA_OP_ADD, 1'b1, 2'h0, 16'h0100, 16'h0000, 4'h3);
    rchk(3'h1, 8'h00);
    // mask 2 with enable set
    wr(cdsa_pkg::OFF_PSW, 8'h60);
    irq(2'h1, 1'b1);
    check("mask loaded", psw, 8'h50);
    rchk(cdsa_pkg::OFF_STAT, 8'h01);
    irq(2'h1, 1'b0);
    irq(2'h0, 1'b1);
    check("mask loaded", psw, 8'h40);
    ret(8'h50);
    ret(8'h60);
    rchk(cdsa_pkg::OFF_STAT, 8'h00);
    wr(cdsa_pkg::OFF_PSW, 8'h30);
    irq(2'h0, 1'b0);
    wr(cdsa_pkg::OFF_PSW, 8'h70);
    irq(2'h3, 1'b0);
    irq(2'h2, 1'b1);
    check("mask loaded", psw, 8'h60);
    ret(8'h70);
    wr(cdsa_pkg::OFF_PSW, 8'h40);
    irq(2'h0, 1'b0);
    ea(cdsa_pkg::CDSA_AM_REG_IND, cdsa_pkg::CDSA_IC_WORD_MOVE, 16'h1235, 16'h0000, 5'd16,
       1'b0, 18'h01235, 1'b0);
    ea(cdsa_pkg::CDSA_AM_REG_IND, cdsa_pkg::CDSA_IC_ALU, 16'h1235, 16'h0000, 5'd16,
       1'b0, 18'h01235, 1'b1);
    ea(cdsa_pkg::CDSA_AM_REG_REL8, cdsa_pkg::CDSA_IC_WORD_MOVE, 16'h1000, 16'h00F0, 5'd8,
       1'b0, 18'h00FF0, 1'b0);
    ea(cdsa_pkg::CDSA_AM_REG_REL16, cdsa_pkg::CDSA_IC_BYTE_MOVE, 16'h1000, 16'h2345, 5'd16,
       1'b0, 18'h03345, 1'b0);
    ea(cdsa_pkg::CDSA_AM_SP_REL, cdsa_pkg::CDSA_IC_BYTE_MOVE, 16'h0000, 16'hFFFF, 5'd4,
       1'b0, 18'h0020F, 1'b0);
    ea(cdsa_pkg::CDSA_AM_ABS, cdsa_pkg::CDSA_IC_BYTE_MOVE, 16'h0000, 16'hFFFF, 5'd12,
       1'b0, 18'h00FFF, 1'b0);
    ea(cdsa_pkg::CDSA_AM_RAM_SHORT, cdsa_pkg::CDSA_IC_BYTE_MOVE, 16'h0000, 16'h0080, 5'd8,
       1'b0, 18'h00080, 1'b0);
    ea(cdsa_pkg::CDSA_AM_IO_SHORT, cdsa_pkg::CDSA_IC_BYTE_MOVE, 16'h0000, 16'h0012, 5'd8,
       1'b0, 18'h03F12, 1'b0);
    ea(cdsa_pkg::CDSA_AM_LAST_ADDR, cdsa_pkg::CDSA_IC_WORD_MOVE, 16'h0000, 16'h0000, 5'd8,
       1'b0, 18'h03F12, 1'b0);
    ea(cdsa_pkg::CDSA_AM_LAST_ADDR, cdsa_pkg::CDSA_IC_ALU, 16'h0000, 16'h0000, 5'd8,
       1'b0, 18'h03F12, 1'b1);
    ea(cdsa_pkg::CDSA_AM_PC_REL, cdsa_pkg::CDSA_IC_BRANCH, 16'h0000, 16'hFFFE, 5'd16,
       1'b1, 18'h000FF, 1'b0);
    ea(cdsa_pkg::CDSA_AM_PC_REL, cdsa_pkg::CDSA_IC_ALU, 16'h0000, 16'hFFFE, 5'd16,
       1'b1, 18'h000FF, 1'b1);
    ea(cdsa_pkg::CDSA_AM_ABS18, cdsa_pkg::CDSA_IC_BYTE_MOVE, 16'h0000, 16'h0000, 5'd16,
       1'b0, 18'h00000, 1'b1);
    // the non-maskable request passes mask 0
    @(posedge clk_sys);
    post_nmi <= 1'b1;
    @(posedge clk_sys);
    post_nmi <= 1'b0;
    #1;
    check("nmi accept", nmi_accept, 1'b1);
    close_out;
  end
endmodule // cdsa_core_bench
